// *** hdl/mtzot_top.sv ***
// Timers 0, 1 and 2 with their control/status, mode and reload registers.
// Assumes a single-cycle SFR bus from the core and one 100 MHz clock.
`timescale 1ns/10ps
module mtzot_top
  import mtzot_pkg::*;
(
  // Clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_n_i,
  // Special function register bus
  input  wire logic [mtzot_pkg::SFR_AW-1:0] sfr_addr_i,
  input  wire logic                         sfr_wr_i,
  input  wire logic                         sfr_rd_i,
  input  wire logic [mtzot_pkg::SFR_DW-1:0] sfr_wdata_i,
  output logic      [mtzot_pkg::SFR_DW-1:0] sfr_rdata_o,
  // Service routine entry, one bit per flag
  input  wire logic [3:0]                   isr_ack_i,
  // External pins
  input  wire logic                         timer0_count_pin_i,
  input  wire logic                         timer1_count_pin_i,
  input  wire logic                         timer2_count_gate_pin_i,
  input  wire logic                         ext_int0_pin_i,
  input  wire logic                         ext_int1_pin_i,
  input  wire logic                         low_freq_clock_i,
  // Flags towards the interrupt controller
  output logic      [mtzot_pkg::SFR_DW-1:0] timer_ctrl_status_o
);
  import mtzot_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  mtzot_pin_if pin ();

  mtzot_pin_sync u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pins_i  ({low_freq_clock_i, ext_int1_pin_i, ext_int0_pin_i,
               timer2_count_gate_pin_i, timer1_count_pin_i, timer0_count_pin_i}),
    .pin     (pin)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [3:0]  pre_cnt_r,  pre_cnt_nxt;
  logic        half_r,     half_nxt;
  logic [7:0]  tcs_r,      tcs_nxt;
  logic [7:0]  timer01_mode_cfg_r,     timer01_mode_cfg_nxt;
  logic [7:0]  t2ctrl_r,   t2ctrl_nxt;
  logic [15:0] t0_r,       t0_nxt;
  logic [15:0] t1_r,       t1_nxt;
  logic [15:0] t2_r,       t2_nxt;
  logic [15:0] crc_r,      crc_nxt;
  logic        timer2_reload_trigger_r,     timer2_reload_trigger_nxt;
  logic [7:0]  rdata_r,    rdata_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and control fields

  logic wr_tcs, wr_timer01_mode_cfg, wr_tl0, wr_th0, wr_tl1, wr_th1;
  logic wr_t2c, wr_crcl, wr_crch, wr_tl2, wr_th2;

  assign wr_tcs  = sfr_wr_i && (sfr_addr_i == ADDR_TCS);
  assign wr_timer01_mode_cfg = sfr_wr_i && (sfr_addr_i == ADDR_TIMER01_MODE_CFG);
  assign wr_tl0  = sfr_wr_i && (sfr_addr_i == ADDR_TL0);
  assign wr_th0  = sfr_wr_i && (sfr_addr_i == ADDR_TH0);
  assign wr_tl1  = sfr_wr_i && (sfr_addr_i == ADDR_TL1);
  assign wr_th1  = sfr_wr_i && (sfr_addr_i == ADDR_TH1);
  assign wr_t2c  = sfr_wr_i && (sfr_addr_i == ADDR_T2CTRL);
  assign wr_crcl = sfr_wr_i && (sfr_addr_i == ADDR_CRCL);
  assign wr_crch = sfr_wr_i && (sfr_addr_i == ADDR_CRCH);
  assign wr_tl2  = sfr_wr_i && (sfr_addr_i == ADDR_TL2);
  assign wr_th2  = sfr_wr_i && (sfr_addr_i == ADDR_TH2);

  mtzot_mode_t t0_mode;
  mtzot_mode_t t1_mode;
  mtzot_t2in_t t2_in;
  logic [1:0]  t2_rl;
  logic        tick12, tick24, t2_pre;
  logic        gate_ok0, gate_ok1, t0_tick, t1_tick, t2_tick, timer2_reload_trigger_fall;

  assign t0_mode = mtzot_mode_t'(timer01_mode_cfg_r[F_TIMER0_OP_SELECT +: 2]);
  assign t1_mode = mtzot_mode_t'(timer01_mode_cfg_r[F_TIMER1_OP_SELECT +: 2]);
  assign t2_in   = mtzot_t2in_t'(t2ctrl_r[F_T2I +: 2]);
  assign t2_rl   = t2ctrl_r[F_T2R +: 2];

  assign tick12  = (pre_cnt_r == PRE_LAST);
  assign tick24  = tick12 && half_r;
  assign t2_pre  = t2ctrl_r[B_TIMER2_PRESCALE_SEL] ? tick24 : tick12;

  // Gate lets a timer run only while its interrupt pin is high
  assign gate_ok0 = !timer01_mode_cfg_r[B_GATE0] || pin.lvl[PIN_INT0];
  assign gate_ok1 = !timer01_mode_cfg_r[B_TIMER1_GATING_BIT] || pin.lvl[PIN_INT1];

  assign t0_tick = tcs_r[B_TR0] && gate_ok0 &&
                   (timer01_mode_cfg_r[B_CT0] ? pin.fall[PIN_T0] : tick12);
  assign t1_tick = tcs_r[B_TR1] && gate_ok1 &&
                   (timer01_mode_cfg_r[B_CT1] ? pin.fall[PIN_T1] : tick12);

  always_comb begin
    unique case (t2_in)
      T2I_STOP:  t2_tick = 1'b0;
      T2I_CLK:   t2_tick = t2_pre;
      T2I_EVENT: t2_tick = pin.fall[PIN_T2];
      T2I_GATED: t2_tick = t2_pre && pin.lvl[PIN_T2];
    endcase
  end

  assign timer2_reload_trigger_fall = timer2_reload_trigger_r && pin.fall[PIN_LFCLK];

  ////////////////////////////////////////////////////////////////////////////
  // One count step for modes 0..2: {overflow, high, low}

  function automatic logic [16:0] step_f(input mtzot_mode_t m,
                                         input logic [7:0]  hi,
                                         input logic [7:0]  lo);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0]  s8;
    s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    s16 = {1'b0, hi, lo} + 17'h0_0001;
    s8  = {1'b0, lo} + 9'h001;
    unique case (m)
      MODE_13:    step_f = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
      MODE_16:    step_f = s16;
      MODE_AR8:   step_f = {s8[8], hi, s8[8] ? hi : s8[7:0]};
      MODE_SPLIT: step_f = {1'b0, hi, lo};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  logic [16:0] st0, st1;
  logic [8:0]  sl0, sh0;
  logic [16:0] s2;
  logic        tf0_set, tf1_set, ie0_set, ie1_set;

  always_comb begin
    pre_cnt_nxt = tick12 ? 4'h0 : 4'(pre_cnt_r + 4'h1);
    half_nxt    = tick12 ? !half_r : half_r;
    timer01_mode_cfg_nxt    = wr_timer01_mode_cfg ? sfr_wdata_i : timer01_mode_cfg_r;
    t2ctrl_nxt  = wr_t2c  ? sfr_wdata_i : t2ctrl_r;
    timer2_reload_trigger_nxt    = pin.fall[PIN_LFCLK] ? !timer2_reload_trigger_r : timer2_reload_trigger_r;
    crc_nxt     = crc_r;
    if (wr_crcl) crc_nxt[7:0]  = sfr_wdata_i;
    if (wr_crch) crc_nxt[15:8] = sfr_wdata_i;

    // Timer 0, including its split form
    tf0_set = 1'b0;
    tf1_set = 1'b0;
    t0_nxt  = t0_r;
    st0     = step_f(t0_mode, t0_r[15:8], t0_r[7:0]);
    sl0     = {1'b0, t0_r[7:0]} + 9'h001;
    sh0     = {1'b0, t0_r[15:8]} + 9'h001;
    if (t0_mode == MODE_SPLIT) begin
      if (t0_tick) begin
        t0_nxt[7:0] = sl0[7:0];
        tf0_set     = sl0[8];
      end
      if (tcs_r[B_TR1] && tick12) begin
        t0_nxt[15:8] = sh0[7:0];
        tf1_set      = sh0[8];
      end
    end else if (t0_tick) begin
      t0_nxt  = st0[15:0];
      tf0_set = st0[16];
    end
    if (wr_tl0) t0_nxt[7:0]  = sfr_wdata_i;
    if (wr_th0) t0_nxt[15:8] = sfr_wdata_i;

    // Timer 1; in mode 3 it holds, and with Timer 0 split it raises no flag
    t1_nxt = t1_r;
    st1    = step_f(t1_mode, t1_r[15:8], t1_r[7:0]);
    if (t1_mode != MODE_SPLIT && t1_tick) begin
      t1_nxt = st1[15:0];
      if (t0_mode != MODE_SPLIT) begin
        tf1_set = st1[16];
      end
    end
    if (wr_tl1) t1_nxt[7:0]  = sfr_wdata_i;
    if (wr_th1) t1_nxt[15:8] = sfr_wdata_i;

    // Timer 2: write beats reload, reload beats plain increment
    t2_nxt = t2_r;
    s2     = {1'b0, t2_r} + 17'h0_0001;
    if (t2_tick) begin
      t2_nxt = (s2[16] && t2_rl == T2R_TIMER0_OP_SELECT) ? crc_r : s2[15:0];
    end
    if (t2_rl == T2R_TIMER1_OP_SELECT && timer2_reload_trigger_fall) begin
      t2_nxt = crc_r;
    end
    if (wr_tl2) t2_nxt[7:0]  = sfr_wdata_i;
    if (wr_th2) t2_nxt[15:8] = sfr_wdata_i;

    // External interrupt detection
    ie0_set = tcs_r[B_IT0] ? pin.fall[PIN_INT0] : !pin.lvl[PIN_INT0];
    ie1_set = tcs_r[B_IT1] ? pin.fall[PIN_INT1] : !pin.lvl[PIN_INT1];

    // Control/status: write, then service clears, then hardware sets win
    tcs_nxt = wr_tcs ? sfr_wdata_i : tcs_r;
    if (isr_ack_i[ACK_TF0]) tcs_nxt[B_TF0] = 1'b0;
    if (isr_ack_i[ACK_IE0]) tcs_nxt[B_IE0] = 1'b0;
    if (isr_ack_i[ACK_TF1]) tcs_nxt[B_TF1] = 1'b0;
    if (isr_ack_i[ACK_IE1]) tcs_nxt[B_IE1] = 1'b0;
    if (tf0_set) tcs_nxt[B_TF0] = 1'b1;
    if (tf1_set) tcs_nxt[B_TF1] = 1'b1;
    if (ie0_set) tcs_nxt[B_IE0] = 1'b1;
    if (ie1_set) tcs_nxt[B_IE1] = 1'b1;

    // Read data; reads have no side effect on any timer
    rdata_nxt = rdata_r;
    if (sfr_rd_i) begin
      unique case (sfr_addr_i)
        ADDR_TCS:    rdata_nxt = tcs_r;
        ADDR_TIMER01_MODE_CFG:   rdata_nxt = timer01_mode_cfg_r;
        ADDR_TL0:    rdata_nxt = t0_r[7:0];
        ADDR_TH0:    rdata_nxt = t0_r[15:8];
        ADDR_TL1:    rdata_nxt = t1_r[7:0];
        ADDR_TH1:    rdata_nxt = t1_r[15:8];
        ADDR_T2CTRL: rdata_nxt = t2ctrl_r;
        ADDR_CRCL:   rdata_nxt = crc_r[7:0];
        ADDR_CRCH:   rdata_nxt = crc_r[15:8];
        ADDR_TL2:    rdata_nxt = t2_r[7:0];
        ADDR_TH2:    rdata_nxt = t2_r[15:8];
        default:     rdata_nxt = RST_BYTE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pre_cnt_r <= 4'h0;
      half_r    <= 1'b0;
      tcs_r     <= RST_BYTE;
      timer01_mode_cfg_r    <= RST_BYTE;
      t2ctrl_r  <= RST_BYTE;
      t0_r      <= RST_WORD;
      t1_r      <= RST_WORD;
      t2_r      <= RST_WORD;
      crc_r     <= RST_WORD;
      timer2_reload_trigger_r    <= 1'b0;
      rdata_r   <= RST_BYTE;
    end else begin
      pre_cnt_r <= pre_cnt_nxt;
      half_r    <= half_nxt;
      tcs_r     <= tcs_nxt;
      timer01_mode_cfg_r    <= timer01_mode_cfg_nxt;
      t2ctrl_r  <= t2ctrl_nxt;
      t0_r      <= t0_nxt;
      t1_r      <= t1_nxt;
      t2_r      <= t2_nxt;
      crc_r     <= crc_nxt;
      timer2_reload_trigger_r    <= timer2_reload_trigger_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  assign sfr_rdata_o         = rdata_r;
  assign timer_ctrl_status_o = tcs_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  prescale_period_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pre_cnt_r == 4'h0) |-> !tick12 [*8] ##4 tick12)
    else $error("machine step not every 12 clocks");

  pin_count_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (t0_mode == MODE_16 && timer01_mode_cfg_r[B_CT0] && !timer01_mode_cfg_r[B_GATE0] && tcs_r[B_TR0]
     && pin.fall[PIN_T0] && !wr_tl0 && !wr_th0)
    |=> t0_r == 16'($past(t0_r) + 16'h0001))
    else $error("timer 0 missed a pin edge");

  timer0_op_select_upper_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (t0_mode == MODE_13 && !wr_tl0) |=> t0_r[7:5] == $past(t0_r[7:5]))
    else $error("mode 0 changed low byte upper bits");

  reload8_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (t0_mode == MODE_AR8 && t0_tick && t0_r[7:0] == 8'hFF && !wr_tl0 && !wr_th0)
    |=> t0_r[7:0] == t0_r[15:8] && tcs_r[B_TF0])
    else $error("auto-reload failed");

  t1_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (t1_mode == MODE_SPLIT && !wr_tl1 && !wr_th1) |=> $stable(t1_r))
    else $error("timer 1 moved in mode 3");

  run_stop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!tcs_r[B_TR0] && t0_mode != MODE_SPLIT && !wr_tl0 && !wr_th0)
    |=> $stable(t0_r))
    else $error("timer 0 moved while stopped");

  t2_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (t2_in == T2I_GATED && !pin.lvl[PIN_T2] && t2_rl != T2R_TIMER1_OP_SELECT
     && !wr_tl2 && !wr_th2) |=> $stable(t2_r))
    else $error("gated timer 2 moved with gate low");

  t2_reload_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (t2_tick && t2_r == 16'hFFFF && t2_rl == T2R_TIMER0_OP_SELECT && !wr_tl2 && !wr_th2)
    |=> t2_r == $past(crc_r))
    else $error("timer 2 overflow reload failed");

  flag_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tf0_set |=> tcs_r[B_TF0])
    else $error("overflow flag lost against clear");
endmodule

// *** hdl/mtzot_pkg.sv ***
// Constants, register map and mode codes of the timer/counter unit.
// Assumes an 8-bit special function register bus from the processor core.
package mtzot_pkg;
  localparam int          SFR_AW        = 8;
  localparam int          SFR_DW        = 8;
  localparam int          NPIN          = 6;
  // Pin order inside the synchroniser
  localparam int          PIN_T0        = 0;
  localparam int          PIN_T1        = 1;
  localparam int          PIN_T2        = 2;
  localparam int          PIN_INT0      = 3;
  localparam int          PIN_INT1      = 4;
  localparam int          PIN_LFCLK     = 5;
  // Register offsets
  localparam logic [7:0]  ADDR_TCS      = 8'h88;
  localparam logic [7:0]  ADDR_TIMER01_MODE_CFG     = 8'h89;
  localparam logic [7:0]  ADDR_TL0      = 8'h8A;
  localparam logic [7:0]  ADDR_TL1      = 8'h8B;
  localparam logic [7:0]  ADDR_TH0      = 8'h8C;
  localparam logic [7:0]  ADDR_TH1      = 8'h8D;
  localparam logic [7:0]  ADDR_T2CTRL   = 8'hC8;
  localparam logic [7:0]  ADDR_CRCL     = 8'hCA;
  localparam logic [7:0]  ADDR_CRCH     = 8'hCB;
  localparam logic [7:0]  ADDR_TL2      = 8'hCC;
  localparam logic [7:0]  ADDR_TH2      = 8'hCD;
  // Control/status bit positions
  localparam int          B_TF1         = 7;
  localparam int          B_TR1         = 6;
  localparam int          B_TF0         = 5;
  localparam int          B_TR0         = 4;
  localparam int          B_IE1         = 3;
  localparam int          B_IT1         = 2;
  localparam int          B_IE0         = 1;
  localparam int          B_IT0         = 0;
  // Mode register fields
  localparam int          B_TIMER1_GATING_BIT       = 7;
  localparam int          B_CT1         = 6;
  localparam int          F_TIMER1_OP_SELECT       = 4;
  localparam int          B_GATE0       = 3;
  localparam int          B_CT0         = 2;
  localparam int          F_TIMER0_OP_SELECT       = 0;
  // Timer 2 control fields
  localparam int          B_TIMER2_PRESCALE_SEL        = 7;
  localparam int          F_T2R         = 3;
  localparam int          F_T2I         = 0;
  // Service routine acknowledge order
  localparam int          ACK_TF0       = 0;
  localparam int          ACK_IE0       = 1;
  localparam int          ACK_TF1       = 2;
  localparam int          ACK_IE1       = 3;
  // Reset values
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [15:0] RST_WORD      = 16'h0000;
  // Prescaler: 12 clocks per machine step
  localparam int          PRE_CYC       = 12;
  localparam logic [3:0]  PRE_LAST      = 4'(PRE_CYC - 1);

  typedef enum logic [1:0] {
    MODE_13    = 2'b00,
    MODE_16    = 2'b01,
    MODE_AR8   = 2'b10,
    MODE_SPLIT = 2'b11
  } mtzot_mode_t;

  typedef enum logic [1:0] {
    T2I_STOP  = 2'b00,
    T2I_CLK   = 2'b01,
    T2I_EVENT = 2'b10,
    T2I_GATED = 2'b11
  } mtzot_t2in_t;

  localparam logic [1:0]  T2R_TIMER0_OP_SELECT     = 2'b10;
  localparam logic [1:0]  T2R_TIMER1_OP_SELECT     = 2'b11;
endpackage

// *** hdl/mtzot_pin_if.sv ***
// Carrier of synchronised pin levels and falling-edge pulses.
// Assumes both ends run on the processor clock.
`timescale 1ns/10ps
interface mtzot_pin_if;
  import mtzot_pkg::*;
  logic [NPIN-1:0] lvl;
  logic [NPIN-1:0] fall;
  modport src (output lvl, output fall);
  modport dst (input  lvl, input  fall);
endinterface

// *** hdl/mtzot_pin_sync.sv ***
// Two-flop synchronisers and falling-edge detectors for the external pins.
// Assumes pins are asynchronous to clk_i and idle high.
`timescale 1ns/10ps
module mtzot_pin_sync
  import mtzot_pkg::*;
(
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_n_i,
  // Raw pins
  input  wire logic [mtzot_pkg::NPIN-1:0] pins_i,
  // Synchronised view
  mtzot_pin_if.src                       pin
);
  logic [NPIN-1:0] s1_r;
  logic [NPIN-1:0] s2_r;
  logic [NPIN-1:0] s3_r;
  logic [NPIN-1:0] fall_r;

  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_pin
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          s1_r[g]   <= 1'b1;
          s2_r[g]   <= 1'b1;
          s3_r[g]   <= 1'b1;
          fall_r[g] <= 1'b0;
        end else begin
          s1_r[g]   <= pins_i[g];
          s2_r[g]   <= s1_r[g];
          s3_r[g]   <= s2_r[g];
          fall_r[g] <= s3_r[g] & ~s2_r[g];
        end
      end
    end
  endgenerate

  assign pin.lvl  = s2_r;
  assign pin.fall = fall_r;
endmodule

// *** testbench/mtzot_core_model.sv ***
// Model of the processor core on the special function register bus.
// Assumes the bench owns the clock; the core moves its strobes on the falling edge.
`timescale 1ns/10ps
module mtzot_core_model (
  // Clock
  input  wire logic       clk_i,
  // Register bus
  output logic      [7:0] sfr_addr_o,
  output logic            sfr_wr_o,
  output logic            sfr_rd_o,
  output logic      [7:0] sfr_wdata_o
);
  initial begin
    sfr_addr_o  = 8'h00;
    sfr_wr_o    = 1'b0;
    sfr_rd_o    = 1'b0;
    sfr_wdata_o = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One access, taken at the rising edge between two falling edges
  task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(negedge clk_i);
    sfr_addr_o  = a;
    sfr_wdata_o = w ? d : ~d;
    sfr_wr_o    = w;
    sfr_rd_o    = !w;
    @(negedge clk_i);
    sfr_wr_o    = 1'b0;
    sfr_rd_o    = 1'b0;
    // Released lines do not keep the last value
    sfr_addr_o  = ~a;
    sfr_wdata_o = ~d;
  endtask
endmodule

// *** testbench/mtzot_top_tb.sv ***
// Self-checking bench of the timer/counter unit.
// Assumes the core model drives the bus and the bench drives the pins.
`timescale 1ns/10ps
module mtzot_top_tb;
  import mtzot_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] addr, wdata, rdata, tcs;
  logic       wr, rd;
  logic       rd_q = 1'b0;
  logic       tcs_q = 1'b0;
  logic [7:0] exp_v;
  logic [3:0] ack = 4'h0;
  logic [5:0] pins = 6'h3F;
  logic [15:0] lfsr = 16'h22AD;
  logic [7:0] rst_a [7] = '{ADDR_TCS, ADDR_TIMER01_MODE_CFG, ADDR_TL0, ADDR_TH1, ADDR_T2CTRL, ADDR_CRCH,
                            8'h90};
  logic [7:0] expq[$];
  logic [7:0] tl_i [4] = '{8'hFE, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0] th_i [4] = '{8'h00, 8'hFF, 8'h80, 8'hFF};
  logic [7:0] tl_e [4] = '{8'hE0, 8'h01, 8'h81, 8'hFF};
  logic [7:0] th_e [4] = '{8'h01, 8'h00, 8'h80, 8'hFF};
  logic [7:0] tf_e [4] = '{8'h00, 8'h01, 8'h01, 8'h00};
  int         miscompares = 0;
  int         n_checks = 0;

  always #5 clk = ~clk;

  mtzot_core_model CORE (.clk_i(clk), .sfr_addr_o(addr), .sfr_wr_o(wr), .sfr_rd_o(rd),
                         .sfr_wdata_o(wdata));
  mtzot_top DUT (.clk_i(clk), .rst_n_i(rst_n), .sfr_addr_i(addr), .sfr_wr_i(wr),
                 .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .isr_ack_i(ack),
                 .timer0_count_pin_i(pins[PIN_T0]), .timer1_count_pin_i(pins[PIN_T1]),
                 .timer2_count_gate_pin_i(pins[PIN_T2]), .ext_int0_pin_i(pins[PIN_INT0]),
                 .ext_int1_pin_i(pins[PIN_INT1]), .low_freq_clock_i(pins[PIN_LFCLK]),
                 .timer_ctrl_status_o(tcs));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: read %h, expected %h", $time, seen, exp);
    end
  endtask
  // Read data is settled one edge after the read is taken
  always @(posedge clk) begin
    if (rd_q) begin
      exp_v = expq.pop_front();
      check(rdata, exp_v);
      if (tcs_q) check(tcs, exp_v);
    end
    rd_q  <= rd;
    tcs_q <= rd && (addr == ADDR_TCS);
  end
  task automatic end_of_test();
    repeat (4) @(posedge clk);
    $display("checks %0d, miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr_r(input logic [7:0] a, input logic [7:0] d);
    CORE.acc(a, d, 1'b1);
  endtask
  task automatic exp_r(input logic [7:0] a, input logic [7:0] d);
    expq.push_back(d);
    CORE.acc(a, d, 1'b0);
  endtask
  function automatic logic [15:0] lfsr_f(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Value v is in force for exactly n clock edges, then s is written
  task automatic run_for(input logic [7:0] a, input logic [7:0] v, input logic [7:0] s,
                         input int n);
    wr_r(a, v);
    repeat (n - 2) @(negedge clk);
    wr_r(a, s);
  endtask
  task automatic pulses(input int p, input int n);
    repeat (n) begin
      pins[p] = 1'b0;
      repeat (4) @(negedge clk);
      pins[p] = 1'b1;
      repeat (4) @(negedge clk);
    end
    repeat (4) @(negedge clk);
  endtask
  task automatic clr_flags();
    @(negedge clk);
    ack = 4'hF;
    @(negedge clk);
    ack = 4'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    foreach (rst_a[i]) exp_r(rst_a[i], RST_BYTE);
    $display("test reset done");
    for (int t = 0; t < 2; t++) begin
      for (int m = 0; m < 4; m++) begin
        if (t == 0 && m == 3) continue;
        // Counter select parks the timer, so a stop leaves the flags alone
        wr_r(ADDR_TIMER01_MODE_CFG, 8'((m + 4) << (4 * t)));
        wr_r(ADDR_TL0 + 8'(t), tl_i[m]);
        wr_r(ADDR_TH0 + 8'(t), th_i[m]);
        wr_r(ADDR_TCS, 8'h10 << (2 * t));
        run_for(ADDR_TIMER01_MODE_CFG, 8'(m << (4 * t)), 8'((m + 4) << (4 * t)), 24);
        exp_r(ADDR_TL0 + 8'(t), tl_e[m]);
        exp_r(ADDR_TH0 + 8'(t), th_e[m]);
        exp_r(ADDR_TCS, (tf_e[m] << (5 + 2 * t)) | (8'h10 << (2 * t)));
        clr_flags();
        exp_r(ADDR_TCS, 8'h10 << (2 * t));
        wr_r(ADDR_TCS, 8'h00);
      end
    end
    $display("test modes done");
    lfsr = lfsr_f(lfsr);
    wr_r(ADDR_TIMER01_MODE_CFG, 8'h05);
    wr_r(ADDR_TL0, lfsr[7:0] & 8'hF0);
    wr_r(ADDR_TCS, 8'h10);
    pulses(PIN_T0, 3);
    wr_r(ADDR_TCS, 8'h00);
    exp_r(ADDR_TL0, (lfsr[7:0] & 8'hF0) + 8'h03);
    wr_r(ADDR_TCS, 8'h01);
    pulses(PIN_INT0, 1);
    pulses(PIN_INT1, 1);
    exp_r(ADDR_TCS, 8'h0B);
    clr_flags();
    exp_r(ADDR_TCS, 8'h01);
    wr_r(ADDR_TIMER01_MODE_CFG, 8'h09);
    for (int g = 0; g < 2; g++) begin
      pins[PIN_INT0] = g[0];
      wr_r(ADDR_TL0, 8'h00);
      repeat (4) @(negedge clk);
      run_for(ADDR_TCS, 8'h10, 8'h00, 24);
      exp_r(ADDR_TL0, 8'(2 * g));
    end
    // Split Timer 0 beside a running 16-bit Timer 1, both run bits for 24 edges
    wr_r(ADDR_TIMER01_MODE_CFG, 8'h13);
    wr_r(ADDR_TL0, 8'hFF);
    wr_r(ADDR_TH0, 8'hFF);
    wr_r(ADDR_TL1, 8'hFF);
    wr_r(ADDR_TH1, 8'hFF);
    wr_r(ADDR_TCS, 8'h50);
    repeat (20) @(negedge clk);
    exp_r(ADDR_TCS, 8'hF0);
    wr_r(ADDR_TCS, 8'h00);
    exp_r(ADDR_TL0, 8'h01);
    exp_r(ADDR_TH0, 8'h01);
    exp_r(ADDR_TL1, 8'h01);
    $display("test events done");
    wr_r(ADDR_TL2, 8'h00);
    run_for(ADDR_T2CTRL, 8'h01, 8'h00, 36);
    exp_r(ADDR_TL2, 8'h03);
    wr_r(ADDR_TL2, 8'h00);
    run_for(ADDR_T2CTRL, 8'h81, 8'h00, 48);
    exp_r(ADDR_TL2, 8'h02);
    for (int g = 0; g < 2; g++) begin
      pins[PIN_T2] = g[0];
      wr_r(ADDR_TL2, 8'h00);
      repeat (4) @(negedge clk);
      run_for(ADDR_T2CTRL, 8'h03, 8'h00, 24);
      exp_r(ADDR_TL2, 8'(2 * g));
    end
    wr_r(ADDR_TL2, 8'h00);
    wr_r(ADDR_T2CTRL, 8'h02);
    pulses(PIN_T2, 2);
    wr_r(ADDR_T2CTRL, 8'h00);
    exp_r(ADDR_TL2, 8'h02);
    wr_r(ADDR_CRCL, 8'h34);
    wr_r(ADDR_CRCH, 8'h12);
    wr_r(ADDR_TL2, 8'hFF);
    wr_r(ADDR_TH2, 8'hFF);
    run_for(ADDR_T2CTRL, 8'h11, 8'h00, 24);
    exp_r(ADDR_TL2, 8'h35);
    exp_r(ADDR_TH2, 8'h12);
    wr_r(ADDR_TL2, 8'h00);
    wr_r(ADDR_TH2, 8'h00);
    wr_r(ADDR_T2CTRL, 8'h18);
    pulses(PIN_LFCLK, 2);
    exp_r(ADDR_TL2, 8'h34);
    exp_r(ADDR_TH2, 8'h12);
    $display("test timer2 done");
    end_of_test();
  end
  // Watchdog, well beyond the length of the sequence
  initial begin
    #200000;
    miscompares++;
    end_of_test();
  end
endmodule
